// >>> rtl/expander_pkg.sv
// Shared constants and state types for both ends of the expander link
package expander_pkg;
    localparam logic [7:0] ADDR_SEL_LOW  = 8'h82;
    localparam logic [7:0] ADDR_SEL_HIGH = 8'h88;
    localparam logic [7:0] GC_ADDR       = 8'h00;
    localparam logic [7:0] GC_RESET      = 8'h06;
    localparam logic [7:0] GC_LATCH      = 8'h04;
    localparam logic [7:0] PTR_WRAP      = 8'h00;
    localparam logic [7:0] LAST_REG_DEF  = 8'hFF;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam int         WR_WIDTH      = 16;
    localparam int         FIFO_DEPTH    = 32;
    localparam int         CORE_CLK_KHZ  = 20000;
    localparam int         STD_KHZ       = 100;
    localparam int         FAST_KHZ      = 400;
    localparam logic [1:0] PH_SETUP      = 2'h0;
    localparam logic [1:0] PH_RISE       = 2'h1;
    localparam logic [1:0] PH_SAMPLE     = 2'h2;
    localparam logic [1:0] PH_FALL       = 2'h3;
    localparam logic [1:0] LAST_BYTE_RD  = 2'h3;
    localparam logic [1:0] LAST_BYTE_WR  = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_RECV = 2'b10,
        ST_SEND = 2'b11
    } dev_state_type;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_START = 2'b01,
        H_BITS  = 2'b10,
        H_STOP  = 2'b11
    } host_state_type;
endpackage

// >>> rtl/expander_link_if.sv
// Two-wire link between bus master and expander slave
`timescale 1ns/10ps
interface expander_link_if;
    logic scl;
    logic sda_host_out;
    logic sda_host_oe;
    logic sda_dev_out;
    logic sda_dev_oe;
    logic sda;

    // Wired-and level of the open-drain data line
    assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));

    modport host (output scl, output sda_host_out, output sda_host_oe, input sda);
    modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe);
endinterface

// >>> rtl/expander_slave.sv
// Expander slave end of the two-wire link, with its write FIFO
// How it works
// - Answer 0x82 when select low, 0x88 high
// - Master opens each exchange with start, address
// - Address LSB one reads, zero writes
// - Matched address: pull data low ninth bit
// - Mismatch: stay released until next start
// - Start: data falls while clock high
// - Ignore all activity before a start
// - Stop: data rises while clock high, ends
// - Unacked read byte then stop returns idle
// - Stop ends register writing
// - Transmitter releases data after eight bits
// - Receiver pulls low to ack, high nacks
// - Sample data on rising serial clock
// - Master changes data only while clock low
// - Works at 100 and 400 kbps
// - Master ends read burst with nack, stop
// - Pointer advances per byte, wraps to zero; a nacked byte leaves it
// - Ack general call, then receive
// - General call 0x06 resets, latches select
`timescale 1ns/10ps
module expander_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;

    // Output register counts as one of the DEPTH slots
    wire [AW:0] used = wr_ptr - rd_ptr;
    wire full  = (used + (AW+1)'(out_valid_o)) == (AW+1)'(DEPTH);
    wire empty = (wr_ptr == rd_ptr);
    wire push  = in_valid_i && !full;
    wire pop   = !empty && (!out_valid_o || out_ready_i);

    assign in_ready_o = !full;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            out_data_o  <= '0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr      <= rd_ptr + (AW+1)'(1);
                out_data_o  <= mem[rd_ptr[AW-1:0]];
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule

module expander_slave #(
    parameter logic [7:0] LAST_REG = expander_pkg::LAST_REG_DEF,
    parameter int         DEPTH    = expander_pkg::FIFO_DEPTH
) (
    input  wire logic       CORE_CLK_I,
    input  wire logic       RST_N_I,
    expander_link_if.device LINK,
    input  wire logic       ADDRESS_SELECT_PIN_I,
    output logic      [7:0] WR_ADDR_O,
    output logic      [7:0] WR_DATA_O,
    output logic            WR_VALID_O,
    input  wire logic       WR_READY_I,
    output logic      [7:0] RD_ADDR_O,
    input  wire logic [7:0] RD_DATA_I,
    output logic            GC_RESET_O,
    output logic            BUSY_O
);
    import expander_pkg::*;

    dev_state_type state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shift;
    logic [7:0]    tx;
    logic [7:0]    ptr;
    logic          drive;
    logic          in_ack;
    logic          is_gc;
    logic          got_ptr;
    logic          mack;
    logic          scl_m, scl_s, scl_d;
    logic          sda_m, sda_s, sda_d;
    logic          sel_m, sel_s;
    logic          sel;
    logic          sel_taken;
    logic          fifo_ready;
    logic [15:0]   fifo_out;

    // Edge finding on synchronised pins; 50 ns sampling covers 100 and 400 kbps
    wire start_cond = scl_s && scl_d && sda_d && !sda_s;
    wire stop_cond  = scl_s && scl_d && !sda_d && sda_s;
    wire scl_rise   = scl_s && !scl_d;
    wire scl_fall   = !scl_s && scl_d;
    wire [7:0] own_addr   = sel ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
    wire       addr_match = (shift[7:1] == own_addr[7:1]);
    wire       gc_match   = (shift == GC_ADDR);
    wire [7:0] next_ptr   = (ptr == LAST_REG) ? PTR_WRAP : ptr + 8'h01;
    wire ack_decide = scl_fall && (bit_cnt == BYTE_BITS) && !in_ack && (state != ST_IDLE);
    wire recv_byte  = ack_decide && (state == ST_RECV);
    wire gc_reset   = recv_byte && is_gc && (shift == GC_RESET);
    wire gc_latch   = recv_byte && is_gc && (gc_reset || shift == GC_LATCH);
    wire fifo_push  = recv_byte && !is_gc && got_ptr && fifo_ready;

    expander_fifo #(
        .WIDTH (WR_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RST_N_I),
        .in_data_i   ({ptr, shift}),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_out),
        .out_valid_o (WR_VALID_O),
        .out_ready_i (WR_READY_I)
    );

    assign WR_ADDR_O        = fifo_out[15:8];
    assign WR_DATA_O        = fifo_out[7:0];
    assign RD_ADDR_O        = ptr;
    assign LINK.sda_dev_oe  = drive;
    assign LINK.sda_dev_out = 1'b0;

    // Two-stage synchronisers, then one delay stage for edges
    always_ff @(posedge CORE_CLK_I) begin
        scl_m <= LINK.scl;
        scl_s <= scl_m;
        scl_d <= scl_s;
        sda_m <= LINK.sda;
        sda_s <= sda_m;
        sda_d <= sda_s;
        sel_m <= ADDRESS_SELECT_PIN_I;
        sel_s <= sel_m;
    end

    // Select pin caught after reset release and on general call 0x04 or 0x06
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            sel       <= 1'b0;
            sel_taken <= 1'b0;
        end else if (!sel_taken || gc_latch) begin
            sel       <= sel_s;
            sel_taken <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            GC_RESET_O <= 1'b0;
            BUSY_O     <= 1'b0;
        end else begin
            GC_RESET_O <= gc_reset;
            BUSY_O     <= (state != ST_IDLE);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            tx      <= 8'h00;
            ptr     <= 8'h00;
            drive   <= 1'b0;
            in_ack  <= 1'b0;
            is_gc   <= 1'b0;
            got_ptr <= 1'b0;
            mack    <= 1'b0;
        end else if (start_cond) begin
            state   <= ST_ADDR;
            bit_cnt <= 4'h0;
            drive   <= 1'b0;
            in_ack  <= 1'b0;
            is_gc   <= 1'b0;
            got_ptr <= 1'b0;
        end else if (stop_cond) begin
            state  <= ST_IDLE;
            drive  <= 1'b0;
            in_ack <= 1'b0;
        end else if (state != ST_IDLE) begin
            if (scl_rise && bit_cnt != BYTE_BITS) begin
                shift   <= {shift[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_rise && bit_cnt == BYTE_BITS && state == ST_SEND && !drive) begin
                mack <= !sda_s;
                if (!sda_s) begin
                    ptr <= next_ptr;
                end
            end
            if (ack_decide) begin
                in_ack <= 1'b1;
                unique case (state)
                    ST_ADDR: begin
                        if (addr_match) begin
                            drive <= 1'b1;
                            mack  <= 1'b1;
                            state <= shift[0] ? ST_SEND : ST_RECV;
                        end else if (gc_match) begin
                            drive <= 1'b1;
                            is_gc <= 1'b1;
                            state <= ST_RECV;
                        end else begin
                            in_ack <= 1'b0;
                            state  <= ST_IDLE;
                        end
                    end
                    ST_RECV: begin
                        if (is_gc) begin
                            drive <= 1'b1;
                            if (gc_reset) begin
                                ptr <= PTR_WRAP;
                            end
                        end else if (!got_ptr) begin
                            ptr     <= shift;
                            got_ptr <= 1'b1;
                            drive   <= 1'b1;
                        end else if (fifo_ready) begin
                            ptr   <= next_ptr;
                            drive <= 1'b1;
                        end
                    end
                    ST_SEND: begin
                        drive <= 1'b0;
                    end
                    ST_IDLE: begin
                        drive <= 1'b0;
                    end
                endcase
            end else if (scl_fall && in_ack) begin
                in_ack  <= 1'b0;
                bit_cnt <= 4'h0;
                drive   <= 1'b0;
                if (state == ST_SEND) begin
                    if (mack) begin
                        tx    <= RD_DATA_I;
                        drive <= !RD_DATA_I[7];
                    end else begin
                        state <= ST_IDLE;
                    end
                end
            end else if (scl_fall && state == ST_SEND && bit_cnt != 4'h0 && bit_cnt != BYTE_BITS) begin
                tx    <= {tx[6:0], 1'b0};
                drive <= !tx[6];
            end
        end
    end
endmodule

// >>> rtl/expander_master.sv
// Bus master end of the expander link: one-byte register read and write
`timescale 1ns/10ps
module expander_master #(
    parameter int SCL_KHZ = expander_pkg::STD_KHZ
) (
    input  wire logic       CORE_CLK_I,
    input  wire logic       RST_N_I,
    expander_link_if.host   LINK,
    input  wire logic       CMD_VALID_I,
    output logic            CMD_READY_O,
    input  wire logic       CMD_READ_I,
    input  wire logic       CMD_SEL_I,
    input  wire logic [7:0] CMD_REG_I,
    input  wire logic [7:0] CMD_DATA_I,
    output logic            DONE_O,
    output logic            NACK_O,
    output logic      [7:0] RD_DATA_O
);
    import expander_pkg::*;

    localparam int         Q_CYC  = CORE_CLK_KHZ / (4 * SCL_KHZ);
    localparam logic [15:0] Q_LAST = 16'(Q_CYC - 1);

    host_state_type hstate;
    logic [15:0]    cnt;
    logic [1:0]     ph;
    logic [1:0]     idx;
    logic [3:0]     bit_idx;
    logic           rd;
    logic [7:0]     dev;
    logic [7:0]     reg_no;
    logic [7:0]     data;
    logic [7:0]     rx;
    logic           ack_seen;
    logic           scl;
    logic           sda_oe;
    logic           sda_m, sda_s;

    wire tick = (cnt == Q_LAST);
    wire [7:0] tx_byte = (idx == 2'h0) ? {dev[7:1], 1'b0} :
                         (idx == 2'h1) ? reg_no :
                         (idx == 2'h2) ? (rd ? {dev[7:1], 1'b1} : data) : 8'hFF;
    // Ninth bit always released: listens for ack, or nacks last read byte
    wire bit_val  = (bit_idx == BYTE_BITS) ? 1'b1 : tx_byte[3'(7 - bit_idx)];
    wire last_idx = rd ? (idx == LAST_BYTE_RD) : (idx == LAST_BYTE_WR);
    wire accept   = CMD_VALID_I && CMD_READY_O;

    assign LINK.scl          = scl;
    assign LINK.sda_host_oe  = sda_oe;
    assign LINK.sda_host_out = 1'b0;

    always_ff @(posedge CORE_CLK_I) begin
        sda_m <= LINK.sda;
        sda_s <= sda_m;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I || hstate == H_IDLE || tick) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            hstate      <= H_IDLE;
            ph          <= PH_SETUP;
            idx         <= 2'h0;
            bit_idx     <= 4'h0;
            rd          <= 1'b0;
            dev         <= 8'h00;
            reg_no      <= 8'h00;
            data        <= 8'h00;
            rx          <= 8'h00;
            ack_seen    <= 1'b0;
            scl         <= 1'b1;
            sda_oe      <= 1'b0;
            CMD_READY_O <= 1'b1;
            DONE_O      <= 1'b0;
            NACK_O      <= 1'b0;
            RD_DATA_O   <= 8'h00;
        end else begin
            DONE_O <= 1'b0;
            if (accept) begin
                hstate      <= H_START;
                CMD_READY_O <= 1'b0;
                ph          <= PH_SETUP;
                idx         <= 2'h0;
                rd          <= CMD_READ_I;
                dev         <= CMD_SEL_I ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
                reg_no      <= CMD_REG_I;
                data        <= CMD_DATA_I;
                NACK_O      <= 1'b0;
            end else if (tick) begin
                ph <= ph + 2'h1;
                unique case (hstate)
                    H_START: begin
                        unique case (ph)
                            PH_SETUP:  sda_oe <= 1'b0;
                            PH_RISE:   scl    <= 1'b1;
                            PH_SAMPLE: sda_oe <= 1'b1;
                            PH_FALL: begin
                                scl     <= 1'b0;
                                hstate  <= H_BITS;
                                bit_idx <= 4'h0;
                            end
                        endcase
                    end
                    H_BITS: begin
                        unique case (ph)
                            PH_SETUP:  sda_oe <= !bit_val;
                            PH_RISE:   scl    <= 1'b1;
                            PH_SAMPLE: begin
                                if (bit_idx == BYTE_BITS) begin
                                    ack_seen <= !sda_s;
                                end else begin
                                    rx <= {rx[6:0], sda_s};
                                end
                            end
                            PH_FALL: begin
                                scl     <= 1'b0;
                                bit_idx <= bit_idx + 4'h1;
                                if (bit_idx == BYTE_BITS) begin
                                    bit_idx <= 4'h0;
                                    if (idx != LAST_BYTE_RD && !ack_seen) begin
                                        NACK_O <= 1'b1;
                                        hstate <= H_STOP;
                                    end else if (rd && idx == 2'h1) begin
                                        idx    <= 2'h2;
                                        hstate <= H_START;
                                    end else if (last_idx) begin
                                        hstate <= H_STOP;
                                        if (rd) begin
                                            RD_DATA_O <= rx;
                                        end
                                    end else begin
                                        idx <= idx + 2'h1;
                                    end
                                end
                            end
                        endcase
                    end
                    H_STOP: begin
                        unique case (ph)
                            PH_SETUP:  sda_oe <= 1'b1;
                            PH_RISE:   scl    <= 1'b1;
                            PH_SAMPLE: sda_oe <= 1'b0;
                            PH_FALL: begin
                                hstate      <= H_IDLE;
                                CMD_READY_O <= 1'b1;
                                DONE_O      <= 1'b1;
                            end
                        endcase
                    end
                    H_IDLE: begin
                        ph <= PH_SETUP;
                    end
                endcase
            end
        end
    end
endmodule

// >>> tb/expander_link_chk.sv
// Wire-level assertions on the master/slave link
`timescale 1ns/10ps
module expander_link_chk (
    input  wire logic CORE_CLK_I,
    input  wire logic RST_N_I,
    input  wire logic scl,
    input  wire logic sda_host_out,
    input  wire logic sda_host_oe,
    input  wire logic sda_dev_out,
    input  wire logic sda_dev_oe,
    input  wire logic sda
);
    logic       prev_scl;
    logic       prev_sda;
    logic       in_frame;
    logic       first_byte;
    logic [3:0] bitcnt;
    wire        start_seen = scl && prev_scl && prev_sda && !sda;
    wire        stop_seen  = scl && prev_scl && !prev_sda && sda;
    wire        scl_rise   = scl && !prev_scl;
    wire        ninth      = scl_rise && bitcnt == 4'h8;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    always_ff @(posedge CORE_CLK_I) begin
        prev_scl <= scl;
        prev_sda <= sda;
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I || stop_seen) in_frame <= 1'b0;
        else if (start_seen) in_frame <= 1'b1;
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I || start_seen) bitcnt <= 4'h0;
        else if (scl_rise) bitcnt <= ninth ? 4'h0 : bitcnt + 4'h1;
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I || ninth) first_byte <= 1'b0;
        else if (start_seen) first_byte <= 1'b1;
    end

    sequence s_drive_on;
        $rose(sda_dev_oe);
    endsequence
    sequence s_next_rise;
        ##[1:400] scl_rise;
    endsequence

    a_dev_idle_quiet: assert property (!in_frame |-> !sda_dev_oe)
        else $error("slave drives outside a frame");
    a_stop_releases: assert property (stop_seen |=> !sda_dev_oe [*8])
        else $error("slave drives after stop");
    a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
        else $error("slave data moved near clock high");
    a_host_change_low: assert property (scl && prev_scl && $changed(sda_host_oe) |-> bitcnt < 4'h2 && !sda_dev_oe)
        else $error("master data moved while clock high");
    a_addr_no_drive: assert property (first_byte && scl_rise && bitcnt < 4'h8 |-> !sda_dev_oe)
        else $error("slave drives during address bits");
    a_ninth_one_drv: assert property (ninth |-> !(sda_host_oe && sda_dev_oe))
        else $error("both ends drive the ninth bit");
    a_dev_open_drain: assert property (sda_dev_oe |-> !sda_dev_out)
        else $error("slave drives a high level");
    a_ack_holds: assert property (s_drive_on |-> sda_dev_oe throughout s_next_rise)
        else $error("slave drive dropped before clock rise");
    a_drive_bounded: assert property (s_drive_on |-> ##[1:600] !sda_dev_oe)
        else $error("slave never releases data");
endmodule

// >>> tb/port_expander_i2c_slave_tb.sv
// Bench: master and slave back to back, plus a hand-driven second link
`timescale 1ns/10ps
module port_expander_i2c_slave_tb;
    localparam int LQ    = 100;
    localparam int LIMIT = 90000;
    logic       clk, rst_n, sel_pin, cmd_valid, cmd_read, cmd_sel, done, nack;
    logic       cmd_ready, wr_valid, wr_ready, wr_valid2, gc2, drove2, gc_seen, wv_seen, busy, sel2;
    logic [7:0] cmd_reg, cmd_data, rd_data_m, wr_addr, wr_data, rd_addr, rd_addr2;
    int         fail_count, tests_run, cycles;
    expander_link_if lnk ();
    expander_link_if lnk2 ();

    expander_master #(.SCL_KHZ(expander_pkg::FAST_KHZ)) expander_master_i (.CORE_CLK_I(clk), .RST_N_I(rst_n),
        .LINK(lnk), .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_READ_I(cmd_read), .CMD_SEL_I(cmd_sel),
        .CMD_REG_I(cmd_reg), .CMD_DATA_I(cmd_data), .DONE_O(done), .NACK_O(nack), .RD_DATA_O(rd_data_m));
    expander_slave #(.DEPTH(32)) expander_slave_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .LINK(lnk),
        .ADDRESS_SELECT_PIN_I(sel_pin), .WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data), .WR_VALID_O(wr_valid),
        .WR_READY_I(wr_ready), .RD_ADDR_O(rd_addr), .RD_DATA_I(rd_addr ^ 8'h5A), .GC_RESET_O(), .BUSY_O(busy));
    expander_slave expander_slave_i2 (.CORE_CLK_I(clk), .RST_N_I(rst_n), .LINK(lnk2),
        .ADDRESS_SELECT_PIN_I(sel2), .WR_ADDR_O(), .WR_DATA_O(), .WR_VALID_O(wr_valid2), .WR_READY_I(1'b1),
        .RD_ADDR_O(rd_addr2), .RD_DATA_I(8'h00), .GC_RESET_O(gc2), .BUSY_O());
    expander_link_chk expander_link_chk_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .scl(lnk.scl),
        .sda_host_out(lnk.sda_host_out), .sda_host_oe(lnk.sda_host_oe), .sda_dev_out(lnk.sda_dev_out),
        .sda_dev_oe(lnk.sda_dev_oe), .sda(lnk.sda));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (lnk2.sda_dev_oe === 1'b1) drove2 <= 1'b1;
        if (gc2 === 1'b1) gc_seen <= 1'b1;
        if (wr_valid2 === 1'b1) wv_seen <= 1'b1;
        if (cycles == LIMIT) begin
            fail_count++;
            $display("unexpected at %0t: run too long", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic do_reset(input logic s);
        @(negedge clk);
        rst_n = 1'b0;
        sel_pin = s;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    task automatic cmd(input logic rd, input logic s, input logic [7:0] r, input logic [7:0] d);
        int n;
        @(negedge clk);
        {cmd_valid, cmd_read, cmd_sel, cmd_reg, cmd_data} = {1'b1, rd, s, r, d};
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 8000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n < 8000, "no completion");
    endtask

    task automatic pop(input logic [7:0] r, input logic [7:0] d);
        @(negedge clk);
        chk(wr_valid === 1'b1 && wr_addr === r && wr_data === d, "buffered write wrong");
        wr_ready = 1'b1;
        @(negedge clk);
        wr_ready = 1'b0;
    endtask

    task automatic t_write_read(input logic s, input logic [7:0] r, input logic [7:0] d);
        cmd(1'b0, s, r, d);
        chk(nack === 1'b0, "write not acked");
        chk(busy === 1'b0 && cmd_ready === 1'b1, "slave busy after stop");
        chk(rd_addr === r + 8'h01, "pointer not advanced");
        pop(r, d);
        cmd(1'b1, s, r, 8'h00);
        chk(nack === 1'b0 && rd_data_m === (r ^ 8'h5A), "read data wrong");
        chk(rd_addr === r, "pointer moved on nack");
    endtask

    task automatic t_mismatch(input logic s);
        cmd(1'b0, s, 8'h21, 8'h77);
        chk(nack === 1'b1 && wr_valid === 1'b0, "foreign write answered");
        cmd(1'b1, s, 8'h21, 8'h00);
        chk(nack === 1'b1, "foreign read answered");
    endtask

    task automatic t_fifo();
        for (int i = 0; i < 33; i++) begin
            cmd(1'b0, 1'b0, 8'(i), ~8'(i));
            chk(nack === (i == 32), "buffer limit wrong");
        end
        for (int i = 0; i < 32; i++) pop(8'(i), ~8'(i));
        @(negedge clk);
        chk(wr_valid === 1'b0, "buffer not empty");
    endtask

    task automatic bb_bit(input logic b, output logic rx);
        lnk2.sda_host_oe = !b;
        #(LQ);
        lnk2.scl = 1'b1;
        #(LQ);
        rx = lnk2.sda;
        #(LQ);
        lnk2.scl = 1'b0;
        #(LQ);
    endtask

    task automatic bb_cond(input logic st);
        lnk2.sda_host_oe = !st;
        #(LQ);
        lnk2.scl = 1'b1;
        #(LQ);
        lnk2.sda_host_oe = st;
        #(LQ);
        if (st) lnk2.scl = 1'b0;
        #(LQ);
    endtask

    task automatic bb_byte(input logic [7:0] v, output logic ack);
        logic rx;
        for (int i = 7; i >= 0; i--) bb_bit(v[i], rx);
        bb_bit(1'b1, rx);
        ack = !rx;
    endtask

    task automatic t_link2();
        logic a;
        drove2 = 1'b0;
        bb_byte(expander_pkg::ADDR_SEL_LOW, a);
        bb_cond(1'b1);
        bb_byte(8'h84, a);
        bb_byte(8'h00, a);
        chk(drove2 === 1'b0, "slave answered without start or match");
        bb_cond(1'b0);
        bb_cond(1'b1);
        bb_byte(expander_pkg::ADDR_SEL_LOW, a);
        chk(a === 1'b1, "own address not acked");
        bb_byte(8'h30, a);
        chk(a === 1'b1 && rd_addr2 === 8'h30, "pointer byte not loaded");
        wv_seen = 1'b0;
        for (int i = 0; i < 4; i++) bb_bit(1'b0, a);
        bb_cond(1'b0);
        #(20 * LQ);
        chk(wv_seen === 1'b0, "cut byte was written");
        bb_cond(1'b1);
        bb_byte(expander_pkg::GC_ADDR, a);
        chk(a === 1'b1, "general call not acked");
        gc_seen = 1'b0;
        bb_byte(expander_pkg::GC_RESET, a);
        bb_cond(1'b0);
        #(20 * LQ);
        chk(a === 1'b1 && gc_seen === 1'b1 && rd_addr2 === expander_pkg::PTR_WRAP, "general call lost");
        sel2 = 1'b1;
        gc_seen = 1'b0;
        bb_cond(1'b1);
        bb_byte(expander_pkg::GC_ADDR, a);
        bb_byte(expander_pkg::GC_LATCH, a);
        bb_cond(1'b0);
        bb_cond(1'b1);
        bb_byte(expander_pkg::ADDR_SEL_HIGH, a);
        bb_cond(1'b0);
        chk(a === 1'b1 && gc_seen === 1'b0 && rd_addr2 === expander_pkg::PTR_WRAP, "select not relatched");
    endtask

    initial begin
        {rst_n, sel_pin, sel2, cmd_valid, cmd_read, cmd_sel, wr_ready} = 7'h00;
        {cmd_reg, cmd_data} = 16'h0000;
        {lnk2.scl, lnk2.sda_host_out, lnk2.sda_host_oe} = 3'h4;
        do_reset(1'b0);
        t_write_read(1'b0, 8'h12, 8'hA5);
        t_write_read(1'b0, 8'hFF, 8'h3C);
        t_mismatch(1'b1);
        t_fifo();
        t_link2();
        do_reset(1'b1);
        t_write_read(1'b1, 8'h40, 8'h81);
        t_mismatch(1'b0);
        tally_and_finish();
    end
endmodule
